// ===== design/pmu_pkg.sv
// constants, register map and carrier types of the power/reset sequencer
// assumes a single 50 MHz clock and a plain strobe-based register port
package pmu_pkg;

  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;

  // power-on wait after an rtc reset, in microseconds (343.78 ms)
  localparam int unsigned RTC_WAIT_US   = 343_780;
  localparam int unsigned RTC_WAIT_CYC  = RTC_WAIT_US * CLK_PER_US;
  // startup watchdog window, seconds
  localparam int unsigned WDOG_S        = 4;
  localparam int unsigned WDOG_CYC      = WDOG_S * CLK_HZ;
  // one wait-register unit: a 32.768 kHz tick, rounded up
  localparam int unsigned WAIT_UNIT_CYC = 1526;
  // core held in cold reset after the peripherals come out of reset
  localparam int unsigned COLD_CYC      = 16;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W  = 28;

  localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] CONTROL_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] WAIT_OFS    = 8'h08;

  // power_status_register fields
  localparam int unsigned RTC_RST_BIT  = 0;
  localparam int unsigned SW_RST_BIT   = 1;
  localparam int unsigned TOUT_BIT     = 2;
  localparam int unsigned BATT_BIT     = 3;
  localparam int unsigned SW_INTR_BIT  = 4;
  localparam int unsigned DCD_STAT_BIT = 5;
  // power_control_register fields
  localparam int unsigned WDOG_CLR_BIT = 0;

  // wait register value equal to 343.78 ms in 32.768 kHz ticks
  localparam logic [DATA_W-1:0] WAIT_RST = 16'h2c01;

  typedef enum logic [5:0] {
    ST_OFF   = 6'b000001,
    ST_WAIT  = 6'b000010,
    ST_CHECK = 6'b000100,
    ST_COLD  = 6'b001000,
    ST_RUN   = 6'b010000,
    ST_DROP  = 6'b100000
  } pmu_state_e;

  typedef struct packed {
    logic [7:0] gpio;
    logic       dcd_n;
    logic       batt_n;
    logic       pwr;
    logic       rst_sw_n;
    logic       rtc_n;
  } pins_s;

  localparam pins_s PINS_IDLE = '{gpio: 8'h00, dcd_n: 1'b1, batt_n: 1'b1,
                                  pwr: 1'b0, rst_sw_n: 1'b1, rtc_n: 1'b1};

  typedef struct packed {
    logic sw_intr;
    logic batt;
    logic tout;
    logic sw_rst;
    logic rtc;
  } flags_s;

  typedef struct packed {
    logic supply_req;
    logic main_supply;
    logic periph_rst;
    logic core_cold_rst;
    logic core_rst;
    logic rtc_rst;
    logic clk_stop;
  } pwr_out_s;

  localparam pwr_out_s OUT_RST = '{supply_req: 1'b0, main_supply: 1'b0, periph_rst: 1'b1,
                                   core_cold_rst: 1'b1, core_rst: 1'b1, rtc_rst: 1'b0,
                                   clk_stop: 1'b1};

endpackage : pmu_pkg

// ===== design/power_reset_startup_sequencer.sv
// power/reset/startup sequencer: reset causes, shutdown, power-on activation
// assumes pins arrive asynchronously; timer alarm, sleep and irq come from this clock
//
// Summary of operation
// - rtc reset pin resets all, sets flag
// - reset switch cold-resets core, sets flag
// - watchdog expiry shuts down, sets timeout flag
// - deep sleep only without pending interrupts
// - low battery at start aborts, sets flag
// - eleven wake-up sources start activation
// - rtc reset activation waits 343.78 ms
// - programmed wait used for other sources
// - power switch edge: request, sample, release
// - battery good: release peripherals, cold start
// - battery low: set flag, back to shutdown
// - power switch edge while running sets interrupt flag
// - wake at sleep entry: supply drop, reactivate
module power_reset_startup_sequencer
  import pmu_pkg::*;
#(
  parameter int unsigned P_RTC_WAIT_CYC  = RTC_WAIT_CYC,
  parameter int unsigned P_WDOG_CYC      = WDOG_CYC,
  parameter int unsigned P_WAIT_UNIT_CYC = WAIT_UNIT_CYC,
  parameter int unsigned P_COLD_CYC      = COLD_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              we_i,
  input  wire logic              re_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              rtc_reset_n_pin_i,
  input  wire logic              reset_switch_n_i,
  input  wire logic              power_switch_in_i,
  input  wire logic              battery_inhibit_n_i,
  input  wire logic              carrier_detect_n_i,
  input  wire logic [7:0]        gpio_wake_i,
  input  wire logic              timer_alarm_i,
  input  wire logic              deep_sleep_i,
  input  wire logic              irq_pending_i,
  output logic                   supply_request_out_o,
  output logic                   main_supply_enable_o,
  output logic                   periph_reset_o,
  output logic                   core_cold_reset_o,
  output logic                   core_reset_o,
  output logic                   rtc_reset_o,
  output logic                   cpu_clock_stop_o
);

  localparam int unsigned NPIN = $bits(pins_s);

  if (P_RTC_WAIT_CYC < 1 || P_WDOG_CYC < 1 || P_COLD_CYC < 1 || P_WAIT_UNIT_CYC < 1 ||
      64'(P_RTC_WAIT_CYC) >= (64'd1 << CNT_W) || 64'(P_WDOG_CYC) >= (64'd1 << CNT_W) ||
      64'(P_WAIT_UNIT_CYC) * 64'd65535 >= (64'd1 << CNT_W))
  begin : g_bad_param
    $error("sequencer counts must be nonzero and fit the counter");
  end

  // pin synchronisers: stage 1 feeds stage 2 only
  pins_s pin_raw;
  pins_s s1_q, s2_q, s3_q, flt_q, flt_d, prev_q;

  assign pin_raw = '{gpio: gpio_wake_i, dcd_n: carrier_detect_n_i,
                     batt_n: battery_inhibit_n_i, pwr: power_switch_in_i,
                     rst_sw_n: reset_switch_n_i, rtc_n: rtc_reset_n_pin_i};

  // a change counts only once stages 2 and 3 agree
  always_comb
  begin
    flt_d = flt_q;
    for (int i = 0; i < NPIN; i++)
    begin
      if (s2_q[i] == s3_q[i])
      begin
        flt_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q   <= PINS_IDLE;
      s2_q   <= PINS_IDLE;
      s3_q   <= PINS_IDLE;
      flt_q  <= PINS_IDLE;
      prev_q <= PINS_IDLE;
    end
    else
    begin
      s1_q   <= pin_raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      flt_q  <= flt_d;
      prev_q <= flt_q;
    end
  end

  logic pwr_rise;
  logic gpio_rise;
  logic dcd_fall;
  logic rst_sw_fall;
  logic rtc_rise;
  logic wake_any;

  assign pwr_rise   = flt_q.pwr & ~prev_q.pwr;
  assign gpio_rise  = |(flt_q.gpio & ~prev_q.gpio);
  assign dcd_fall   = ~flt_q.dcd_n & prev_q.dcd_n;
  assign rst_sw_fall = ~flt_q.rst_sw_n & prev_q.rst_sw_n;
  assign rtc_rise   = flt_q.rtc_n & ~prev_q.rtc_n;
  assign wake_any   = pwr_rise | gpio_rise | dcd_fall | timer_alarm_i;

  // register decode
  logic wr_status, wr_control, wr_wait;

  always_comb
  begin
    wr_status  = 1'b0;
    wr_control = 1'b0;
    wr_wait    = 1'b0;
    if (we_i && addr_i == STATUS_OFS)
    begin
      wr_status = 1'b1;
    end
    else if (we_i && addr_i == CONTROL_OFS)
    begin
      wr_control = 1'b1;
    end
    else if (we_i && addr_i == WAIT_OFS)
    begin
      wr_wait = 1'b1;
    end
  end

  // sequencer
  pmu_state_e        st_q, st_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [CNT_W-1:0]  wait_ld;
  flags_s            fl_q, fl_d;
  logic [DATA_W-1:0] wait_q, wait_d;
  pwr_out_s          out_q, out_d;
  logic              wd_clr;

  assign wd_clr  = wr_control & wdata_i[WDOG_CLR_BIT];
  // zero programmed wait still gives two cycles of supply request
  assign wait_ld = CNT_W'(64'(wait_q) * 64'(P_WAIT_UNIT_CYC));

  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    fl_d   = fl_q;
    wait_d = wait_q;
    // clears first so a same-cycle hardware set wins
    if (wr_status)
    begin
      fl_d.rtc     = fl_q.rtc & wdata_i[RTC_RST_BIT];
      fl_d.sw_rst  = fl_q.sw_rst & wdata_i[SW_RST_BIT];
      fl_d.tout    = fl_q.tout & wdata_i[TOUT_BIT];
      fl_d.batt    = fl_q.batt & wdata_i[BATT_BIT];
      fl_d.sw_intr = fl_q.sw_intr & wdata_i[SW_INTR_BIT];
    end
    if (wr_wait)
    begin
      wait_d = wdata_i;
    end
    case (st_q)
      ST_OFF:
      begin
        if (wake_any)
        begin
          st_d  = ST_WAIT;
          cnt_d = wait_ld - CNT_W'(wait_ld != '0);
        end
      end
      ST_WAIT:
      begin
        if (cnt_q == '0)
        begin
          st_d = ST_CHECK;
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_CHECK:
      begin
        if (flt_q.batt_n)
        begin
          st_d  = ST_COLD;
          cnt_d = CNT_W'(P_COLD_CYC - 1);
        end
        else
        begin
          st_d    = ST_OFF;
          fl_d.batt = 1'b1;
        end
      end
      ST_COLD:
      begin
        if (cnt_q == '0)
        begin
          st_d  = ST_RUN;
          cnt_d = CNT_W'(P_WDOG_CYC - 1);
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_RUN:
      begin
        if (pwr_rise)
        begin
          fl_d.sw_intr = 1'b1;
        end
        if (deep_sleep_i && !irq_pending_i)
        begin
          // a wake racing sleep entry skips the supply request
          st_d = (wake_any || rst_sw_fall) ? ST_DROP : ST_OFF;
        end
        else if (wd_clr)
        begin
          cnt_d = CNT_W'(P_WDOG_CYC - 1);
        end
        else if (cnt_q == '0)
        begin
          st_d      = ST_OFF;
          fl_d.tout = 1'b1;
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_DROP:
      begin
        st_d  = ST_COLD;
        cnt_d = CNT_W'(P_COLD_CYC - 1);
      end
      default:
      begin
        st_d = ST_OFF;
      end
    endcase
    if (rst_sw_fall && st_q != ST_DROP && !(st_q == ST_RUN && st_d == ST_DROP))
    begin
      st_d        = ST_COLD;
      cnt_d       = CNT_W'(P_COLD_CYC - 1);
      fl_d.sw_rst = 1'b1;
    end
    if (!flt_q.rtc_n)
    begin
      st_d     = ST_OFF;
      fl_d.rtc = 1'b1;
      wait_d   = WAIT_RST;
    end
    else if (rtc_rise)
    begin
      st_d  = ST_WAIT;
      cnt_d = CNT_W'(P_RTC_WAIT_CYC - 1);
    end
  end

  // outputs registered from the next state, rtc reset from the filtered pin, so each pin is a flip-flop
  always_comb
  begin
    out_d               = OUT_RST;
    out_d.supply_req    = (st_d == ST_WAIT) || (st_d == ST_CHECK);
    out_d.main_supply   = (st_d != ST_OFF) && (st_d != ST_DROP);
    out_d.periph_rst    = (st_d != ST_COLD) && (st_d != ST_RUN);
    out_d.core_cold_rst = (st_d != ST_RUN);
    out_d.core_rst      = (st_d != ST_RUN);
    out_d.rtc_rst       = ~flt_q.rtc_n;
    out_d.clk_stop      = (st_d != ST_COLD) && (st_d != ST_RUN);
  end

  logic [DATA_W-1:0] rdata_d, rdata_q;

  always_comb
  begin
    rdata_d = '0;
    if (re_i && addr_i == STATUS_OFS)
    begin
      rdata_d[RTC_RST_BIT]  = fl_q.rtc;
      rdata_d[SW_RST_BIT]   = fl_q.sw_rst;
      rdata_d[TOUT_BIT]     = fl_q.tout;
      rdata_d[BATT_BIT]     = fl_q.batt;
      rdata_d[SW_INTR_BIT]  = fl_q.sw_intr;
      rdata_d[DCD_STAT_BIT] = ~flt_q.dcd_n;
    end
    else if (re_i && addr_i == WAIT_OFS)
    begin
      rdata_d = wait_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q    <= ST_OFF;
      cnt_q   <= '0;
      fl_q    <= '0;
      wait_q  <= WAIT_RST;
      out_q   <= OUT_RST;
      rdata_q <= '0;
    end
    else
    begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      fl_q    <= fl_d;
      wait_q  <= wait_d;
      out_q   <= out_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o              = rdata_q;
  assign supply_request_out_o = out_q.supply_req;
  assign main_supply_enable_o = out_q.main_supply;
  assign periph_reset_o       = out_q.periph_rst;
  assign core_cold_reset_o    = out_q.core_cold_rst;
  assign core_reset_o         = out_q.core_rst;
  assign rtc_reset_o          = out_q.rtc_rst;
  assign cpu_clock_stop_o     = out_q.clk_stop;

endmodule : power_reset_startup_sequencer

// ===== testbench/pmu_checker.sv
// pin-level checks of the power/reset sequencer
// assumes a bind onto the top module by port name
module pmu_checker
  import pmu_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              re_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              rtc_reset_n_pin_i,
  input wire logic              deep_sleep_i,
  input wire logic              irq_pending_i,
  input wire logic              supply_request_out_o,
  input wire logic              main_supply_enable_o,
  input wire logic              periph_reset_o,
  input wire logic              core_cold_reset_o,
  input wire logic              core_reset_o,
  input wire logic              rtc_reset_o,
  input wire logic              cpu_clock_stop_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_supply_main: assert property (supply_request_out_o |-> main_supply_enable_o && core_reset_o)
    else $error("supply request outside activation");
  chk_core_pair: assert property (core_cold_reset_o == core_reset_o)
    else $error("core resets differ");
  chk_cold_order: assert property ($fell(periph_reset_o) |-> core_cold_reset_o && !supply_request_out_o)
    else $error("peripherals released out of order");
  chk_run_state: assert property (!core_reset_o |-> !periph_reset_o && !cpu_clock_stop_o)
    else $error("core running with peripherals held");
  // eight samples cover the pin synchroniser and filter
  chk_rtc_hold: assert property (!rtc_reset_n_pin_i [*8] |-> rtc_reset_o && core_reset_o)
    else $error("rtc pin low without reset");
  chk_sleep_block: assert property (deep_sleep_i && irq_pending_i && !core_reset_o |=> !core_reset_o)
    else $error("sleep taken with irq pending");
  chk_sleep_off: assert property (deep_sleep_i && !irq_pending_i && !core_reset_o |-> ##[1:3] core_reset_o)
    else $error("sleep not taken");
  chk_rdata_idle: assert property (!$past(re_i) |-> rdata_o == '0)
    else $error("read data outside read slot");

  cover property ($fell(core_reset_o));
  cover property ($rose(supply_request_out_o));
  cover property (deep_sleep_i && irq_pending_i);
  cover property ($fell(main_supply_enable_o) ##1 $rose(main_supply_enable_o));
endmodule : pmu_checker

// ===== testbench/pmu_pins_model.sv
// switches, battery sense and rtc reset pin around the sequencer
// assumes the bench calls drive; pins move just after a clock edge
module pmu_pins_model
(
  input  wire logic clk_i,
  output logic      power_switch_o,
  output logic      reset_switch_n_o,
  output logic      battery_n_o,
  output logic      rtc_reset_n_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    power_switch_o = 1'b0;
    reset_switch_n_o = 1'b1;
    battery_n_o = 1'b1;
    rtc_reset_n_o = 1'b1;
  end

  task drive(input int p, input logic v);
    @(posedge clk_i);
    case (p)
      0: power_switch_o <= v;
      1: reset_switch_n_o <= v;
      2: battery_n_o <= v;
      default: rtc_reset_n_o <= v;
    endcase
  endtask : drive
endmodule : pmu_pins_model

// ===== testbench/power_reset_startup_sequencer_test.sv
// self-checking bench of the power/reset sequencer
// assumes shortened counts; switch, battery and rtc pins come from the partner model
module power_reset_startup_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pmu_pkg::*;

  localparam int RTC_W = 50;
  localparam int WDOG = 200;
  localparam int COLD = 4;
  localparam int WAIT = 10; // wait reg 5, unit 2

  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic              we_i = 1'b0;
  logic              re_i = 1'b0;
  logic              carrier_detect_n_i = 1'b1;
  logic [7:0]        gpio_wake_i = '0;
  logic              timer_alarm_i = 1'b0;
  logic              deep_sleep_i = 1'b0;
  logic              irq_pending_i = 1'b0;
  wire logic         rtc_reset_n_pin_i, reset_switch_n_i, power_switch_in_i, battery_inhibit_n_i;
  logic [DATA_W-1:0] rdata_o;
  logic              supply_request_out_o, main_supply_enable_o, periph_reset_o;
  logic              core_cold_reset_o, core_reset_o, rtc_reset_o, cpu_clock_stop_o;
  int                fails = 0;
  int                checks_done = 0;
  int                k;

  power_reset_startup_sequencer #(.P_RTC_WAIT_CYC(RTC_W), .P_WDOG_CYC(WDOG), .P_WAIT_UNIT_CYC(2),
    .P_COLD_CYC(COLD)) u_dut (.*);
  pmu_pins_model u_pins (.clk_i(clk_i), .power_switch_o(power_switch_in_i), .reset_switch_n_o(reset_switch_n_i),
    .battery_n_o(battery_inhibit_n_i), .rtc_reset_n_o(rtc_reset_n_pin_i));

  always #10 clk_i = ~clk_i;

  task end_of_test();
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask : rd

  // measures the supply request pulse, then the outcome of the battery check
  task act(input int n, input logic ok);
    for (k = 0; k < 99 && supply_request_out_o !== 1'b1; k++) @(negedge clk_i);
    for (k = 0; k < 999 && supply_request_out_o === 1'b1; k++) @(negedge clk_i);
    chk(16'(k >= n && k <= n + 2), 16'h1);
    repeat (COLD + 3) @(negedge clk_i);
    chk(16'({core_reset_o, main_supply_enable_o}), 16'({!ok, 1'b1} & {1'b1, ok}));
  endtask : act

  task sleep(input logic irq);
    @(posedge clk_i);
    deep_sleep_i <= 1'b1;
    irq_pending_i <= irq;
    @(posedge clk_i);
    deep_sleep_i <= 1'b0;
    irq_pending_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk(16'({core_reset_o, cpu_clock_stop_o, periph_reset_o}), 16'({3{!irq}}));
  endtask : sleep

  initial
  begin
    #200_000;
    fails++;
    end_of_test();
  end

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(STATUS_OFS, '0);
    rd(WAIT_OFS, WAIT_RST);
    rd(8'h0c, '0);
    wr(WAIT_OFS, 16'h0005);
    u_pins.drive(3, 1'b0);
    repeat (10) @(negedge clk_i);
    chk(16'({rtc_reset_o, core_cold_reset_o}), 16'h3);
    u_pins.drive(3, 1'b1);
    act(RTC_W, 1'b1);
    rd(WAIT_OFS, WAIT_RST);
    rd(STATUS_OFS, 16'h0001);
    wr(STATUS_OFS, '0);
    wr(WAIT_OFS, 16'h0005);
    sleep(1'b1);
    sleep(1'b0);
    u_pins.drive(2, 1'b0);
    u_pins.drive(0, 1'b1);
    act(WAIT, 1'b0);
    u_pins.drive(0, 1'b0);
    u_pins.drive(2, 1'b1);
    rd(STATUS_OFS, 16'h0008);
    // each gpio, carrier detect and timer alarm wake source in turn, from shutdown
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_i);
      gpio_wake_i <= (i < 8) ? 8'h01 << i : 8'h00;
      carrier_detect_n_i <= (i != 8);
      timer_alarm_i <= (i == 9);
      act(WAIT, 1'b1);
      if (i == 8) rd(STATUS_OFS, 16'h0028);
      @(posedge clk_i);
      gpio_wake_i <= '0;
      carrier_detect_n_i <= 1'b1;
      timer_alarm_i <= 1'b0;
      sleep(1'b0);
    end
    u_pins.drive(0, 1'b1);
    act(WAIT, 1'b1);
    u_pins.drive(0, 1'b0);
    u_pins.drive(1, 1'b0);
    for (k = 0; k < 12 && core_cold_reset_o !== 1'b1; k++) @(negedge clk_i);
    chk(16'(core_cold_reset_o), 16'h1);
    u_pins.drive(1, 1'b1);
    repeat (COLD + 4) @(negedge clk_i);
    chk(16'(core_reset_o), 16'h0);
    // wake racing sleep entry: one supply drop, restart without supply request
    @(posedge clk_i);
    deep_sleep_i <= 1'b1;
    timer_alarm_i <= 1'b1;
    @(posedge clk_i);
    deep_sleep_i <= 1'b0;
    timer_alarm_i <= 1'b0;
    @(negedge clk_i);
    chk(16'({main_supply_enable_o, supply_request_out_o}), 16'h0);
    repeat (COLD + 2) @(negedge clk_i);
    chk(16'({core_reset_o, main_supply_enable_o, supply_request_out_o}), 16'h2);
    repeat (3)
    begin
      repeat (WDOG - 50) @(posedge clk_i);
      wr(CONTROL_OFS, 16'h0001 << WDOG_CLR_BIT);
    end
    repeat (WDOG - 10) @(negedge clk_i);
    chk(16'(core_reset_o), 16'h0);
    repeat (20) @(negedge clk_i);
    chk(16'(core_reset_o), 16'h1);
    rd(STATUS_OFS, 16'h000e);
    wr(STATUS_OFS, '0);
    rd(STATUS_OFS, '0);
    end_of_test();
  end
endmodule : power_reset_startup_sequencer_test

bind power_reset_startup_sequencer pmu_checker u_chk (.*);
